// file: design/dpl_regs.sv
// Register bank of the memory power domain: power cap, energy, range and throttle.
`timescale 1ns/10ps
module dpl_regs
#(
  parameter int unsigned REFRESH_CYCLES = dpl_pkg::REFRESH_CYCLES,
  parameter logic [14:0] TDP_POWER = 15'h0000,
  parameter logic [14:0] MIN_POWER = 15'h0000,
  parameter logic [14:0] MAX_POWER = 15'h7FFF,
  parameter logic [5:0] MAX_WINDOW = 6'h3F
)
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Register read and write requests.
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic [dpl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dpl_pkg::DATA_W-1:0] i_wr_data,
  output logic [dpl_pkg::DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_wr_ack,
  output logic o_wr_ignored,
  output logic o_addr_err,
  // Domain activity.
  input wire logic [dpl_pkg::ENERGY_INC_W-1:0] i_energy_inc,
  input wire logic i_time_unit_tick,
  input wire logic i_throttled,
  // Cap settings and energy refresh towards the power controller.
  output logic [14:0] o_cap_limit,
  output logic o_cap_enable,
  output logic [4:0] o_window_exp,
  output logic [1:0] o_window_frac,
  output logic [34:0] o_window_tenths,
  output logic o_window_over_max,
  output logic o_cap_locked,
  output logic o_energy_refresh
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (REFRESH_CYCLES < 2 || REFRESH_CYCLES >= (1 << dpl_pkg::REFRESH_CNT_W))
    begin : g_bad_refresh
      $error("Refresh period out of range for the refresh counter.");
    end
    if (MIN_POWER > MAX_POWER)
    begin : g_bad_power
      $error("Minimum power exceeds maximum power.");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------------
  // Returns the window length in tenths of a time unit: (10 + Z) << Y.
  function automatic logic [34:0] win_tenths(input logic [6:0] win);
    logic [34:0] base;
    base = {31'h0000_0000, dpl_pkg::WIN_F_BASE_TENTHS} + {33'h0_0000_0000, win[6:5]};
    win_tenths = base << win[4:0];
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic sel_cap;
  logic sel_energy;
  logic sel_range;
  logic sel_throttle;
  logic sel_any;

  always_comb
  begin
    sel_cap = (i_addr == dpl_pkg::IDX_POWER_CAP);
    sel_energy = (i_addr == dpl_pkg::IDX_ENERGY_COUNTER);
    sel_range = (i_addr == dpl_pkg::IDX_POWER_RANGE);
    sel_throttle = (i_addr == dpl_pkg::IDX_THROTTLE_TIME);
    sel_any = sel_cap | sel_energy | sel_range | sel_throttle;
  end

  // ----------------------------------------------------------------------
  // Power cap register
  // ----------------------------------------------------------------------
  logic [31:0] cap_reg;
  logic [31:0] cap_next;
  logic cap_wr_ok;

  assign cap_wr_ok = i_wr_req & sel_cap & ~cap_reg[dpl_pkg::CAP_LOCK_BIT];

  always_comb
  begin
    cap_next = cap_reg;
    if (cap_wr_ok)
    begin
      // Limit, enable, window and lock are kept; the gaps are dropped.
      cap_next = i_wr_data[31:0] & dpl_pkg::CAP_WR_MASK;
    end
  end

  // Only reset clears the lock, since every write is refused while it is set.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cap_reg <= dpl_pkg::CAP_RESET;
    end
    else
    begin
      cap_reg <= cap_next;
    end
  end

  // ----------------------------------------------------------------------
  // Cap outputs
  // ----------------------------------------------------------------------
  logic [6:0] cap_win;
  logic [34:0] win_now;
  logic [34:0] win_max_tenths;

  assign cap_win = cap_reg[dpl_pkg::CAP_WIN_MSB:dpl_pkg::CAP_WIN_LSB];
  assign win_now = win_tenths(cap_win);
  assign win_max_tenths = {29'h0000_0000, MAX_WINDOW} * dpl_pkg::TENTHS_PER_UNIT;

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cap_limit <= 15'h0000;
      o_cap_enable <= 1'b0;
      o_window_exp <= 5'h00;
      o_window_frac <= 2'h0;
      o_window_tenths <= 35'h0_0000_0000;
      o_window_over_max <= 1'b0;
      o_cap_locked <= 1'b0;
    end
    else
    begin
      o_cap_limit <= cap_reg[dpl_pkg::CAP_LIMIT_MSB:dpl_pkg::CAP_LIMIT_LSB];
      // The controller sees the limit even while the enable bit is clear.
      o_cap_enable <= cap_reg[dpl_pkg::CAP_ENABLE_BIT];
      o_window_exp <= cap_reg[dpl_pkg::CAP_WIN_Y_MSB:dpl_pkg::CAP_WIN_LSB];
      o_window_frac <= cap_reg[dpl_pkg::CAP_WIN_MSB:dpl_pkg::CAP_WIN_F_LSB];
      // Tenths of a time unit; the controller multiplies by the time unit.
      o_window_tenths <= win_now;
      o_window_over_max <= (win_now > win_max_tenths);
      o_cap_locked <= cap_reg[dpl_pkg::CAP_LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Energy accumulator and refresh timer
  // ----------------------------------------------------------------------
  localparam logic [23:0] REFRESH_LAST = 24'(REFRESH_CYCLES - 1);

  logic [23:0] refresh_cnt_reg;
  logic refresh_due;
  dpl_acc_if energy_if();
  dpl_acc_if throttle_if();

  assign refresh_due = (refresh_cnt_reg == REFRESH_LAST);

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      refresh_cnt_reg <= 24'h00_0000;
    end
    else if (refresh_due)
    begin
      refresh_cnt_reg <= 24'h00_0000;
    end
    else
    begin
      refresh_cnt_reg <= refresh_cnt_reg + 24'h00_0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_energy_refresh <= 1'b0;
    end
    else
    begin
      o_energy_refresh <= refresh_due;
    end
  end

  // Energy is summed every cycle but only shown at each refresh.
  assign energy_if.add_en = 1'b1;
  assign energy_if.add_val = {16'h0000, i_energy_inc};
  assign energy_if.publish = refresh_due;

  dpl_accum u_energy
  (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .acc(energy_if.acc)
  );

  // ----------------------------------------------------------------------
  // Throttle accumulator
  // ----------------------------------------------------------------------
  // One count per throttled time unit gives a wrap time of many hours.
  assign throttle_if.add_en = i_time_unit_tick & i_throttled;
  assign throttle_if.add_val = 32'h0000_0001;
  assign throttle_if.publish = 1'b1;

  dpl_accum u_throttle
  (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .acc(throttle_if.acc)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [63:0] range_val;
  logic [63:0] rd_mux;

  always_comb
  begin
    range_val = 64'h0000_0000_0000_0000;
    range_val[dpl_pkg::RNG_TDP_LSB +: dpl_pkg::POWER_W] = TDP_POWER;
    range_val[dpl_pkg::RNG_MIN_LSB +: dpl_pkg::POWER_W] = MIN_POWER;
    range_val[dpl_pkg::RNG_MAX_LSB +: dpl_pkg::POWER_W] = MAX_POWER;
    range_val[dpl_pkg::RNG_WIN_LSB +: dpl_pkg::MAXWIN_W] = MAX_WINDOW;
  end

  // Reads only select a value; no state changes on a read.
  always_comb
  begin
    rd_mux = 64'h0000_0000_0000_0000;
    if (sel_cap)
    begin
      rd_mux = {32'h0000_0000, cap_reg};
    end
    else if (sel_energy)
    begin
      rd_mux = {32'h0000_0000, energy_if.total};
    end
    else if (sel_range)
    begin
      rd_mux = range_val;
    end
    else if (sel_throttle)
    begin
      rd_mux = {32'h0000_0000, throttle_if.total};
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rd_data <= 64'h0000_0000_0000_0000;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req)
      begin
        o_rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write answers and address errors
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wr_ack <= 1'b0;
      o_wr_ignored <= 1'b0;
    end
    else
    begin
      o_wr_ack <= i_wr_req;
      // Read-only targets, a locked cap and unknown indices drop the write.
      o_wr_ignored <= i_wr_req & ~cap_wr_ok;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_addr_err <= 1'b0;
    end
    else
    begin
      o_addr_err <= (i_rd_req | i_wr_req) & ~sel_any;
    end
  end

endmodule

// file: design/dpl_pkg.sv
// Package of constants for the memory power-cap register bank.
package dpl_pkg;

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned ACC_W = 32;
  localparam logic [3:0] IDX_POWER_CAP = 4'h0;
  localparam logic [3:0] IDX_ENERGY_COUNTER = 4'h1;
  localparam logic [3:0] IDX_POWER_RANGE = 4'h2;
  localparam logic [3:0] IDX_THROTTLE_TIME = 4'h3;

  // ----------------------------------------------------------------------
  // Power cap register fields
  // ----------------------------------------------------------------------
  localparam int unsigned CAP_LIMIT_LSB = 0;
  localparam int unsigned CAP_LIMIT_MSB = 14;
  localparam int unsigned CAP_ENABLE_BIT = 15;
  localparam int unsigned CAP_WIN_LSB = 17;
  localparam int unsigned CAP_WIN_MSB = 23;
  localparam int unsigned CAP_WIN_Y_MSB = 21;
  localparam int unsigned CAP_WIN_F_LSB = 22;
  localparam int unsigned CAP_LOCK_BIT = 31;
  localparam logic [31:0] CAP_WR_MASK = 32'h80FE_FFFF;
  localparam logic [31:0] CAP_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Power range register fields
  // ----------------------------------------------------------------------
  localparam int unsigned RNG_TDP_LSB = 0;
  localparam int unsigned RNG_MIN_LSB = 16;
  localparam int unsigned RNG_MAX_LSB = 32;
  localparam int unsigned RNG_WIN_LSB = 48;
  localparam int unsigned POWER_W = 15;
  localparam int unsigned MAXWIN_W = 6;

  // ----------------------------------------------------------------------
  // Window decode and timing
  // ----------------------------------------------------------------------
  localparam int unsigned WIN_TENTHS_W = 35;
  localparam logic [3:0] WIN_F_BASE_TENTHS = 4'hA;
  localparam logic [34:0] TENTHS_PER_UNIT = 35'h0_0000_000A;
  localparam int unsigned ENERGY_INC_W = 16;
  localparam int unsigned REFRESH_CNT_W = 24;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam longint unsigned REFRESH_PERIOD_PS = 64'd1_000_000_000;
  localparam int unsigned REFRESH_CYCLES = int'(REFRESH_PERIOD_PS / CLK_PERIOD_PS);

endpackage

// file: design/dpl_acc_if.sv
// Interface between the register bank and its wrapping accumulators.
`timescale 1ns/10ps
interface dpl_acc_if;
  logic add_en;
  logic [31:0] add_val;
  logic publish;
  logic [31:0] total;

  modport ctrl
  (
    output add_en,
    output add_val,
    output publish,
    input total
  );

  modport acc
  (
    input add_en,
    input add_val,
    input publish,
    output total
  );
endinterface

// file: design/dpl_accum.sv
// Wrapping 32-bit accumulator with a separately published snapshot.
`timescale 1ns/10ps
module dpl_accum
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Control and result.
  dpl_acc_if.acc acc
);

  // ----------------------------------------------------------------------
  // Running sum
  // ----------------------------------------------------------------------
  logic [31:0] run_reg;
  logic [31:0] run_next;
  logic [31:0] total_reg;

  // The sum drops its carry, so it wraps modulo 2^32 with no flag.
  always_comb
  begin
    run_next = run_reg;
    if (acc.add_en)
    begin
      run_next = run_reg + acc.add_val;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      run_reg <= 32'h0000_0000;
    end
    else
    begin
      run_reg <= run_next;
    end
  end

  // ----------------------------------------------------------------------
  // Published snapshot
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      total_reg <= 32'h0000_0000;
    end
    else if (acc.publish)
    begin
      total_reg <= run_next;
    end
  end

  assign acc.total = total_reg;

endmodule

// file: test/dpl_regs_monitor.sv
// Concurrent checks on the ports of the memory power-cap register bank.
`timescale 1ns/10ps
module dpl_regs_monitor
#(
  parameter int unsigned REFRESH_CYCLES = 16,
  parameter logic [5:0] MAX_WINDOW = 6'h3F
)
(
  // Clock and reset.
  input logic i_mclk,
  input logic i_resetn,
  // Register port.
  input logic i_rd_req,
  input logic i_wr_req,
  input logic [3:0] i_addr,
  input logic [63:0] o_rd_data,
  input logic o_rd_valid,
  input logic o_wr_ack,
  input logic o_wr_ignored,
  input logic o_addr_err,
  // Cap settings and refresh.
  input logic [14:0] o_cap_limit,
  input logic [4:0] o_window_exp,
  input logic [1:0] o_window_frac,
  input logic [34:0] o_window_tenths,
  input logic o_window_over_max,
  input logic o_cap_locked,
  input logic o_energy_refresh
);
  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic up;
  logic seen;
  int unsigned gap;

  // The outputs are only meaningful from the second edge after release.
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn)
    begin
      up <= 1'b0;
      seen <= 1'b0;
      gap <= 0;
    end
    else
    begin
      up <= 1'b1;
      seen <= seen | o_energy_refresh;
      gap <= o_energy_refresh ? 0 : gap + 1;
    end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_rd_valid;
    i_rd_req |=> o_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

  property p_ro_write;
    i_wr_req && i_addr != 4'h0 |=> o_wr_ack && o_wr_ignored;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write taken");

  property p_lock;
    o_cap_locked && i_wr_req && i_addr == 4'h0 |=> o_wr_ack && o_wr_ignored;
  endproperty
  a_lock: assert property (p_lock) else $error("locked cap write taken");

  property p_lock_hold;
    o_cap_locked |=> o_cap_locked && $stable(o_cap_limit) && $stable(o_window_tenths);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked cap changed");

  property p_range;
    i_rd_req && i_addr == 4'h2 |=> o_rd_data[53:48] == MAX_WINDOW && o_rd_data[63:54] == 10'h0
      && !o_rd_data[47] && !o_rd_data[31] && !o_rd_data[15];
  endproperty
  a_range: assert property (p_range) else $error("range read wrong");

  property p_unmapped;
    i_rd_req && i_addr > 4'h3 |=> o_addr_err && o_rd_data == 64'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");

  property p_refresh;
    seen |-> o_energy_refresh == (gap == REFRESH_CYCLES - 1);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh spacing wrong");

  property p_window;
    up |-> o_window_tenths == ({31'h0, 4'hA + {2'b0, o_window_frac}} << o_window_exp);
  endproperty
  a_window: assert property (p_window) else $error("window decode wrong");

  property p_over_max;
    up |-> o_window_over_max == (o_window_tenths > 35'(MAX_WINDOW) * 35'hA);
  endproperty
  a_over_max: assert property (p_over_max) else $error("window limit flag wrong");

  c_refresh: cover property (o_energy_refresh);
  c_lock: cover property (o_cap_locked && i_wr_req && i_addr == 4'h0);
  c_unmapped: cover property (i_rd_req && i_addr > 4'h3);
endmodule

bind dpl_regs dpl_regs_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES), .MAX_WINDOW(MAX_WINDOW)) u_mon
(
  .i_mclk, .i_resetn, .i_rd_req, .i_wr_req, .i_addr, .o_rd_data, .o_rd_valid, .o_wr_ack,
  .o_wr_ignored, .o_addr_err, .o_cap_limit, .o_window_exp, .o_window_frac, .o_window_tenths,
  .o_window_over_max, .o_cap_locked, .o_energy_refresh
);

// file: test/dpl_regs_bench.sv
// Self-checking bench for the memory power-cap register bank.
`timescale 1ns/10ps
module dpl_regs_bench;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_rd_req = 1'b0;
  logic i_wr_req = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [63:0] i_wr_data = 64'h0;
  logic [15:0] i_energy_inc = 16'h0;
  logic i_time_unit_tick = 1'b0;
  logic i_throttled = 1'b0;
  logic [63:0] o_rd_data;
  logic [34:0] o_window_tenths;
  logic [14:0] o_cap_limit;
  logic [4:0] o_window_exp;
  logic [1:0] o_window_frac;
  logic o_rd_valid, o_wr_ack, o_wr_ignored, o_addr_err, o_cap_enable;
  logic o_window_over_max, o_cap_locked, o_energy_refresh;
  logic [63:0] e1;
  int bad_count = 0;
  int compares = 0;

  dpl_regs #(.REFRESH_CYCLES(16), .TDP_POWER(15'h1234), .MIN_POWER(15'h0456),
    .MAX_POWER(15'h7ABC), .MAX_WINDOW(6'h2A)) dut
  (
    .i_mclk, .i_resetn, .i_rd_req, .i_wr_req, .i_addr, .i_wr_data, .o_rd_data, .o_rd_valid,
    .o_wr_ack, .o_wr_ignored, .o_addr_err, .i_energy_inc, .i_time_unit_tick, .i_throttled,
    .o_cap_limit, .o_cap_enable, .o_window_exp, .o_window_frac, .o_window_tenths,
    .o_window_over_max, .o_cap_locked, .o_energy_refresh
  );

  always #2.5 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [63:0] exp, input logic [63:0] m = '1);
    @(posedge i_mclk);
    i_rd_req <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd_req <= 1'b0;
    #1;
    chk("rd_valid", 64'h1, {63'h0, o_rd_valid});
    chk("rd_data", exp, o_rd_data & m);
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] d, input logic ign);
    @(posedge i_mclk);
    i_wr_req <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_mclk);
    i_wr_req <= 1'b0;
    #1;
    chk("wr_ack", 64'h1, {63'h0, o_wr_ack});
    chk("wr_ignored", {63'h0, ign}, {63'h0, o_wr_ignored});
  endtask

  task automatic cap_out(input logic [59:0] exp);
    @(posedge i_mclk);
    #1;
    chk("cap_out", {4'h0, exp}, {4'h0, o_window_over_max, o_cap_locked, o_cap_enable,
      o_window_frac, o_window_exp, o_cap_limit, o_window_tenths});
  endtask

  task automatic tick(input logic thr);
    @(posedge i_mclk);
    i_throttled <= thr;
    i_time_unit_tick <= 1'b1;
    @(posedge i_mclk);
    i_time_unit_tick <= 1'b0;
  endtask

  task automatic wait_refresh();
    int n;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    while (o_energy_refresh !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      chk("refresh_timeout", 64'h1, 64'h0);
      results();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_values();
    rd(4'h0, 64'h0);
    rd(4'h3, 64'h0);
    rd(4'h2, 64'h002A_7ABC_0456_1234);
    rd(4'h9, 64'h0);
    chk("addr_err", 64'h1, {63'h0, o_addr_err});
  endtask

  task automatic t_cap_fields();
    wr(4'h0, 64'hFFFF_FFFF_7FFF_FFFF, 1'b0);
    rd(4'h0, 64'h0000_0000_00FE_FFFF);
    cap_out({1'b1, 1'b0, 1'b1, 2'h3, 5'h1F, 15'h7FFF, 35'h6_8000_0000});
    wr(4'h0, 64'h0000_0000_7F43_8123, 1'b0);
    rd(4'h0, 64'h0000_0000_0042_8123);
    cap_out({1'b0, 1'b0, 1'b1, 2'h1, 5'h01, 15'h0123, 35'h16});
  endtask

  task automatic t_read_only();
    wr(4'h1, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
    wr(4'h2, 64'h0, 1'b1);
    wr(4'h3, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
    wr(4'hF, 64'h1, 1'b1);
    chk("addr_err", 64'h1, {63'h0, o_addr_err});
    rd(4'h2, 64'h002A_7ABC_0456_1234);
    chk("addr_err", 64'h0, {63'h0, o_addr_err});
    rd(4'h1, 64'h0);
    rd(4'h3, 64'h0);
  endtask

  task automatic t_throttle();
    repeat (5) tick(1'b1);
    repeat (3) tick(1'b0);
    rd(4'h3, 64'h5);
  endtask

  task automatic t_energy();
    @(posedge i_mclk);
    i_energy_inc <= 16'h0100;
    wait_refresh();
    wait_refresh();
    rd(4'h1, 64'h0, 64'hFFFF_FFFF_0000_0000);
    e1 = o_rd_data;
    wait_refresh();
    rd(4'h1, e1 + 64'h1000);
    rd(4'h1, e1 + 64'h1000);
  endtask

  task automatic t_lock();
    wr(4'h0, 64'h0000_0000_8000_8005, 1'b0);
    wr(4'h0, 64'h0, 1'b1);
    wr(4'h0, 64'h0000_0000_0000_7FFF, 1'b1);
    rd(4'h0, 64'h0000_0000_8000_8005);
    cap_out({1'b0, 1'b1, 1'b1, 2'h0, 5'h00, 15'h0005, 35'hA});
    @(posedge i_mclk);
    do_reset();
    rd(4'h0, 64'h0);
    wr(4'h0, 64'h0000_0000_0000_0007, 1'b0);
    rd(4'h0, 64'h7);
  endtask

  initial
  begin
    do_reset();
    t_reset_values();
    t_cap_fields();
    t_read_only();
    t_throttle();
    t_energy();
    t_lock();
    results();
  end
endmodule
